// >>> pmc_pkg.sv
// output control package
package pmc_pkg;
  // command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_START_CFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_DEFAULT = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEFAULT = 8'h12;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_TARGET = 8'h21;
  localparam logic [7:0] CMD_ADJUST = 8'h22;
  localparam logic [7:0] CMD_CAL = 8'h23;
  localparam logic [7:0] CMD_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
  localparam logic [7:0] CMD_SLEW = 8'h27;
  localparam logic [7:0] CMD_SLOPE = 8'h28;
  localparam logic [7:0] CMD_DUTY = 8'h32;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_PHASE = 8'h37;
  // on/off/margin request codes
  localparam logic [7:0] OP_OFF_NOW = 8'h04;
  localparam logic [7:0] OP_OFF_SOFT = 8'h44;
  localparam logic [7:0] OP_ON_NOM = 8'h84;
  localparam logic [7:0] OP_ON_LOW = 8'h94;
  localparam logic [7:0] OP_ON_HIGH = 8'hA4;
  // start control codes
  localparam logic [7:0] CFG_ALWAYS = 8'h00;
  localparam logic [7:0] CFG_PIN_SOFT = 8'h16;
  localparam logic [7:0] CFG_PIN_HARD = 8'h17;
  localparam logic [7:0] CFG_BUS = 8'h1A;
  // reset values
  localparam logic [15:0] VOUT_FORMAT_VAL = 16'h0013;
  localparam logic [15:0] OP_RST = 16'h0004;
  localparam logic [15:0] START_CFG_RST = 16'h0016;
  localparam logic [15:0] ADJUST_RST = 16'h0000;
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [15:0] SLEW_RST = 16'hBA00;
  localparam logic [15:0] SLOPE_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'hEADB;
  localparam logic [7:0] SEC_LEVEL_ONE = 8'h01;
  localparam logic [15:0] SLEW_FASTEST = 16'h7BFF;
  // field masks and positions
  localparam logic [15:0] BYTE_MASK = 16'h00FF;
  localparam logic [15:0] PHASE_MASK = 16'h0FFF;
  localparam int PH_GRP_LSB = 8;
  localparam int PH_CNT_LSB = 4;
  localparam int PH_POS_LSB = 0;
  // strap scaling in percent
  localparam int CEIL_PCT = 110;
  localparam int MHI_PCT = 105;
  localparam int MLO_PCT = 95;
  localparam int PCT_BASE = 100;
  // shift from slew and droop units to set-point steps
  localparam int SLEW_SHIFT = 3;
  localparam int SLOPE_SHIFT = 3;
  // settings slots
  localparam int NUM_SET = 13;
  localparam int IX_OP = 0;
  localparam int IX_CFG = 1;
  localparam int IX_TARGET = 2;
  localparam int IX_ADJUST = 3;
  localparam int IX_CAL = 4;
  localparam int IX_CEIL = 5;
  localparam int IX_MHI = 6;
  localparam int IX_MLO = 7;
  localparam int IX_SLEW = 8;
  localparam int IX_SLOPE = 9;
  localparam int IX_DUTY = 10;
  localparam int IX_FREQ = 11;
  localparam int IX_PHASE = 12;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int STORE_TIME_US = 20000;
  localparam int STORE_CYCLES_DOC = STORE_TIME_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_OFF = 2'b01,
    ST_RUN = 2'b10,
    ST_SOFT = 2'b11
  } pmc_state_e;
endpackage

// >>> pmc_output_control.sv
// command decode, settings and output on/off control
// Operation
// [R1] 04h cuts output at once, 44h soft
// [R2] 84h nominal, 94h low, A4h high margin
// [R3] host sends members first, reference last
// [R4] config 00h: run whenever powered
// [R5] 16h pin soft off, 17h pin hard
// [R6] 1Ah: only bus command starts and stops
// [R7] clear faults pulses, never restarts output
// [R8] store default: copy, busy 20 ms
// [R9] restore default, then security level one
// [R10] store user: copy, busy 20 ms
// [R11] restore user, security one, also power-up; at power-up only security one is set, uvalid is clear
// [R12] power-up: default store, then user store; reset clears dvalid and uvalid, so neither loads
// [R13] format register reads fixed 13h
// [R14] target capped by ceiling and 110% strap
// [R15] signed trim and offset add, reset zero
// [R16] ceiling caps output, defaults 1.10 strap
// [R17] margins select target, default 1.05/0.95
// [R18] margin changes ramp at slew setting
// [R19] load-line slope lowers target with current
// [R20] duty limit resets to EADBh
// [R21] host writes frequency only while disabled
// [R22] phase word: group, count, position fields
// [R23] linear eleven: 5-bit exponent, 11-bit mantissa
// [R24] linear sixteen: mantissa times 2^-13
// [R25] out-of-range target clamps to lowest limit
module pmc_output_control
  import pmc_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DOC,
  parameter logic [15:0] FREQ_DEFAULT = 16'h0000,
  parameter logic [15:0] PHASE_DEFAULT = 16'h0000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [7:0] load_amps,
  input wire logic enable_pin,
  input wire logic [15:0] strap_vout,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_error,
  output logic cmd_busy,
  output logic power_run,
  output logic [15:0] vout_setpoint,
  output logic [15:0] duty_limit,
  output logic [15:0] switch_freq,
  output logic [3:0] phase_group,
  output logic [4:0] phase_count,
  output logic [3:0] phase_pos,
  output logic [7:0] security_level,
  output logic clear_faults
);

  // code to settings index, bit 4 set if stored
  function automatic logic [4:0] code_index(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    unique case (c)
      CMD_OPERATION: r = {1'b1, 4'(IX_OP)};
      CMD_START_CFG: r = {1'b1, 4'(IX_CFG)};
      CMD_TARGET: r = {1'b1, 4'(IX_TARGET)};
      CMD_ADJUST: r = {1'b1, 4'(IX_ADJUST)};
      CMD_CAL: r = {1'b1, 4'(IX_CAL)};
      CMD_CEILING: r = {1'b1, 4'(IX_CEIL)};
      CMD_MARGIN_HI: r = {1'b1, 4'(IX_MHI)};
      CMD_MARGIN_LO: r = {1'b1, 4'(IX_MLO)};
      CMD_SLEW: r = {1'b1, 4'(IX_SLEW)};
      CMD_SLOPE: r = {1'b1, 4'(IX_SLOPE)};
      CMD_DUTY: r = {1'b1, 4'(IX_DUTY)};
      CMD_FREQ: r = {1'b1, 4'(IX_FREQ)};
      CMD_PHASE: r = {1'b1, 4'(IX_PHASE)};
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // linear eleven word to integer with extra shift
  function automatic int l11_val(input logic [15:0] w, input int sh);
    int m;
    int e;
    m = int'($signed(w[10:0]));
    e = int'($signed(w[15:11])) + sh; // [R23]
    if (e >= 0) begin
      return m <<< ((e > 20) ? 20 : e);
    end
    return m >>> -e;
  endfunction

  // strap scaled by percent
  function automatic logic [15:0] pct(input logic [15:0] v, input int p);
    int t;
    t = int'(v) * p / PCT_BASE;
    return t[15:0];
  endfunction

  // one slew step toward goal
  function automatic logic [15:0] ramp(input logic [15:0] cur,
                                       input logic [15:0] goal,
                                       input int step,
                                       input logic fast);
    int d;
    d = int'(goal) - int'(cur);
    if (fast) begin
      return goal; // [R18]
    end
    if (d >= 0) begin
      return (d <= step) ? goal : 16'(int'(cur) + step);
    end
    return (-d <= step) ? goal : 16'(int'(cur) - step);
  endfunction

  logic [1:0] rst_sync;
  logic rst_n;
  logic en_meta;
  logic en_sync;
  logic [15:0] strap_meta;
  logic [15:0] strap_q;

  // reset and pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      strap_meta <= 16'h0000;
      strap_q <= 16'h0000;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
      en_meta <= enable_pin;
      en_sync <= en_meta;
      strap_meta <= strap_vout;
      strap_q <= strap_meta;
    end
  end
  assign rst_n = rst_sync[1];

  pmc_state_e state;
  pmc_state_e next_state;
  logic [15:0] mem [NUM_SET];
  logic [15:0] next_mem [NUM_SET];
  logic [15:0] dstore [NUM_SET];
  logic [15:0] next_dstore [NUM_SET];
  logic [15:0] ustore [NUM_SET];
  logic [15:0] next_ustore [NUM_SET];
  logic [NUM_SET-1:0] dvalid;
  logic [NUM_SET-1:0] next_dvalid;
  logic [NUM_SET-1:0] uvalid;
  logic [NUM_SET-1:0] next_uvalid;
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  logic [7:0] tick_cnt;
  logic [7:0] next_tick_cnt;
  logic next_rsp_valid;
  logic [15:0] next_rsp_rdata;
  logic next_rsp_error;
  logic next_power_run;
  logic [15:0] next_vout_setpoint;
  logic [7:0] next_security_level;
  logic next_clear_faults;
  logic [15:0] strap_ref;
  logic [15:0] next_strap_ref;

  logic [4:0] dec;
  logic tick;
  logic [7:0] op;
  logic [7:0] cfg;
  logic want_on;
  logic soft_off;
  logic [15:0] sel;
  logic [15:0] limit;
  logic [15:0] goal;
  int sum;
  int step;
  logic fast;

  // set-point goal: target, offsets, droop, limits
  always_comb begin
    op = mem[IX_OP][7:0];
    cfg = mem[IX_CFG][7:0];
    if (op == OP_ON_LOW) begin
      sel = mem[IX_MLO]; // [R2] [R17]
    end else if (op == OP_ON_HIGH) begin
      sel = mem[IX_MHI]; // [R2] [R17]
    end else begin
      sel = mem[IX_TARGET];
    end
    sum = int'(sel) + int'($signed(mem[IX_ADJUST]))
        + int'($signed(mem[IX_CAL])); // [R15] [R24]
    sum = sum - l11_val(mem[IX_SLOPE], SLOPE_SHIFT) * int'(load_amps); // [R19]
    limit = pct(strap_ref, CEIL_PCT); // [R14]
    if (mem[IX_CEIL] < limit) begin
      limit = mem[IX_CEIL]; // [R16] [R25]
    end
    if (sum < 0) begin
      goal = 16'h0000;
    end else if (sum > int'(limit)) begin
      goal = limit; // [R14] [R25]
    end else begin
      goal = sum[15:0];
    end
    step = l11_val(mem[IX_SLEW], SLEW_SHIFT);
    if (step < 1) begin
      step = 1;
    end
    fast = (mem[IX_SLEW] == SLEW_FASTEST); // [R18]
  end

  // start and stop request
  always_comb begin
    want_on = 1'b0;
    soft_off = 1'b0;
    unique case (cfg)
      CFG_ALWAYS: want_on = 1'b1; // [R4]
      CFG_PIN_SOFT: begin
        want_on = en_sync; // [R5]
        soft_off = 1'b1;
      end
      CFG_PIN_HARD: want_on = en_sync; // [R5]
      CFG_BUS: begin
        want_on = op[7]; // [R6]
        soft_off = (op == OP_OFF_SOFT); // [R1]
      end
      default: want_on = 1'b0;
    endcase
  end

  // next values of command, store and run state
  always_comb begin
    next_state = state;
    next_mem = mem;
    next_dstore = dstore;
    next_ustore = ustore;
    next_dvalid = dvalid;
    next_uvalid = uvalid;
    next_busy_cnt = busy_cnt;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_rsp_error = 1'b0;
    next_power_run = power_run;
    next_vout_setpoint = vout_setpoint;
    next_security_level = security_level;
    next_clear_faults = 1'b0;
    next_strap_ref = strap_ref;
    tick = (tick_cnt == 8'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
    dec = code_index(cmd_code);
    if (busy_cnt != 32'h0) begin
      next_busy_cnt = busy_cnt - 32'h1;
    end
    if (state == ST_INIT) begin
      // factory values; store overlays never apply, dvalid and uvalid clear on reset
      next_strap_ref = strap_q;
      next_mem[IX_OP] = OP_RST;
      next_mem[IX_CFG] = START_CFG_RST; // [R5]
      next_mem[IX_TARGET] = strap_q;
      next_mem[IX_ADJUST] = ADJUST_RST; // [R15]
      next_mem[IX_CAL] = CAL_RST; // [R15]
      next_mem[IX_CEIL] = pct(strap_q, CEIL_PCT); // [R16]
      next_mem[IX_MHI] = pct(strap_q, MHI_PCT); // [R17]
      next_mem[IX_MLO] = pct(strap_q, MLO_PCT); // [R17]
      next_mem[IX_SLEW] = SLEW_RST; // [R18]
      next_mem[IX_SLOPE] = SLOPE_RST; // [R19]
      next_mem[IX_DUTY] = DUTY_RST; // [R20]
      next_mem[IX_FREQ] = FREQ_DEFAULT;
      next_mem[IX_PHASE] = PHASE_DEFAULT;
      for (int i = 0; i < NUM_SET; i++) begin
        if (dvalid[i]) begin
          next_mem[i] = dstore[i]; // [R12]
        end
        if (uvalid[i]) begin
          next_mem[i] = ustore[i]; // [R11] [R12]
        end
      end
      next_security_level = SEC_LEVEL_ONE; // [R11]
      next_state = ST_OFF;
    end else if (cmd_valid && busy_cnt == 32'h0) begin
      next_rsp_valid = 1'b1;
      if (cmd_write) begin
        unique case (cmd_code)
          CMD_CLEAR_FAULTS: next_clear_faults = 1'b1; // [R7]
          CMD_STORE_DEFAULT: begin
            next_dstore = mem; // [R8]
            next_dvalid = '1;
            next_busy_cnt = 32'(STORE_CYCLES); // [R8]
          end
          CMD_RESTORE_DEFAULT: begin
            for (int i = 0; i < NUM_SET; i++) begin
              if (dvalid[i]) begin
                next_mem[i] = dstore[i]; // [R9]
              end
            end
            next_security_level = SEC_LEVEL_ONE; // [R9]
          end
          CMD_STORE_USER: begin
            next_ustore = mem; // [R10]
            next_uvalid = '1;
            next_busy_cnt = 32'(STORE_CYCLES); // [R10]
          end
          CMD_RESTORE_USER: begin
            for (int i = 0; i < NUM_SET; i++) begin
              if (uvalid[i]) begin
                next_mem[i] = ustore[i]; // [R11]
              end
            end
            next_security_level = SEC_LEVEL_ONE; // [R11]
          end
          default: begin
            if (!dec[4]) begin
              next_rsp_error = 1'b1; // [R13]
            end else if (dec[3:0] <= 4'(IX_CFG)) begin
              next_mem[dec[3:0]] = cmd_wdata & BYTE_MASK;
            end else if (dec[3:0] == 4'(IX_PHASE)) begin
              next_mem[dec[3:0]] = cmd_wdata & PHASE_MASK; // [R22]
            end else begin
              next_mem[dec[3:0]] = cmd_wdata;
            end
          end
        endcase
      end else if (cmd_code == CMD_VOUT_FORMAT) begin
        next_rsp_rdata = VOUT_FORMAT_VAL; // [R13]
      end else if (dec[4]) begin
        next_rsp_rdata = mem[dec[3:0]];
      end else begin
        next_rsp_rdata = 16'h0000;
        next_rsp_error = 1'b1;
      end
    end
    // run state; clear faults never touches it
    unique case (state)
      ST_INIT: next_power_run = 1'b0;
      ST_OFF: begin
        if (want_on) begin
          next_state = ST_RUN; // [R2] [R4] [R5] [R6]
          next_power_run = 1'b1;
          next_vout_setpoint = goal;
        end
      end
      ST_RUN: begin
        if (!want_on && soft_off) begin
          next_state = ST_SOFT; // [R1] [R5]
        end else if (!want_on) begin
          next_state = ST_OFF; // [R1] [R5]
          next_power_run = 1'b0;
          next_vout_setpoint = 16'h0000;
        end else if (tick) begin
          next_vout_setpoint = ramp(vout_setpoint, goal, step, fast); // [R18]
        end
      end
      ST_SOFT: begin
        if (want_on) begin
          next_state = ST_RUN;
        end else if (!soft_off) begin
          next_state = ST_OFF; // [R1]
          next_power_run = 1'b0;
          next_vout_setpoint = 16'h0000;
        end else if (vout_setpoint == 16'h0000) begin
          next_state = ST_OFF;
          next_power_run = 1'b0;
        end else if (tick) begin
          next_vout_setpoint = ramp(vout_setpoint, 16'h0000, step, fast); // [R1]
        end
      end
    endcase
  end

  // stores keep contents across reset
  always_ff @(posedge clk) begin
    dstore <= next_dstore;
    ustore <= next_ustore;
    mem <= next_mem;
  end

  // control state and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_INIT;
      dvalid <= '0;
      uvalid <= '0;
      busy_cnt <= 32'h0;
      tick_cnt <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_error <= 1'b0;
      cmd_busy <= 1'b1;
      power_run <= 1'b0;
      vout_setpoint <= 16'h0000;
      security_level <= SEC_LEVEL_ONE;
      clear_faults <= 1'b0;
      strap_ref <= 16'h0000;
      duty_limit <= DUTY_RST;
      switch_freq <= FREQ_DEFAULT;
      phase_group <= 4'h0;
      phase_count <= 5'h10;
      phase_pos <= 4'h0;
    end else begin
      state <= next_state;
      dvalid <= next_dvalid;
      uvalid <= next_uvalid;
      busy_cnt <= next_busy_cnt;
      tick_cnt <= next_tick_cnt;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      rsp_error <= next_rsp_error;
      cmd_busy <= (next_state == ST_INIT) || (next_busy_cnt != 32'h0); // [R8] [R10]
      power_run <= next_power_run;
      vout_setpoint <= next_vout_setpoint;
      security_level <= next_security_level;
      clear_faults <= next_clear_faults;
      strap_ref <= next_strap_ref;
      duty_limit <= next_mem[IX_DUTY]; // [R20]
      switch_freq <= next_mem[IX_FREQ];
      phase_group <= next_mem[IX_PHASE][PH_GRP_LSB +: 4]; // [R22]
      phase_count <= (next_mem[IX_PHASE][PH_CNT_LSB +: 4] == 4'h0) ? 5'h10
                     : {1'b0, next_mem[IX_PHASE][PH_CNT_LSB +: 4]}; // [R22]
      phase_pos <= next_mem[IX_PHASE][PH_POS_LSB +: 4]; // [R22]
    end
  end

endmodule

// >>> pmc_output_control_sva.sv
// output control checker
module pmc_output_control_sva
  import pmc_pkg::*;
#(
  parameter int STORE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_error,
  input wire logic cmd_busy,
  input wire logic power_run,
  input wire logic [15:0] vout_setpoint,
  input wire logic [4:0] phase_count,
  input wire logic clear_faults
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_MAX = STORE_CYCLES + 4;
  logic take;
  logic [7:0] cfg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // taken command, start config
  assign take = cmd_valid & ~cmd_busy;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= START_CFG_RST[7:0];
    end else if (take && cmd_write && cmd_code == CMD_START_CFG) begin
      cfg <= cmd_wdata[7:0];
    end
  end
  sequence s_op(logic [7:0] v);
    take && cmd_write && cmd_code == CMD_OPERATION && cmd_wdata[7:0] == v && cfg == CFG_BUS;
  endsequence
  sequence s_store;
    take && cmd_write && (cmd_code == CMD_STORE_USER || cmd_code == CMD_STORE_DEFAULT);
  endsequence
  property p_rsp; take |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_drop; cmd_valid && cmd_busy |=> !rsp_valid; endproperty
  a_drop: assert property (p_drop) else $error("busy answer");
  property p_fmt;
    take && !cmd_write && cmd_code == CMD_VOUT_FORMAT |=>
      !rsp_error && rsp_rdata == VOUT_FORMAT_VAL;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format read wrong");
  property p_fmt_wr; take && cmd_write && cmd_code == CMD_VOUT_FORMAT |=> rsp_error; endproperty
  a_fmt_wr: assert property (p_fmt_wr) else $error("format write ok");
  property p_clr; take && cmd_write && cmd_code == CMD_CLEAR_FAULTS |-> ##[1:2] clear_faults;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear pulse");
  property p_no_restart;
    take && cmd_code == CMD_CLEAR_FAULTS && !power_run && cfg == CFG_BUS |=> !power_run [*3];
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("clear restarted output");
  property p_store; s_store |=> cmd_busy [*8]; endproperty
  a_store: assert property (p_store) else $error("busy short");
  property p_store_end; s_store |-> ##[1:BUSY_MAX] !cmd_busy; endproperty
  a_store_end: assert property (p_store_end) else $error("busy long");
  property p_on; s_op(OP_ON_NOM) and !power_run |-> ##2 power_run; endproperty
  a_on: assert property (p_on) else $error("no start");
  property p_off; s_op(OP_OFF_NOW) |-> ##2 !power_run && vout_setpoint == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("late off");
  property p_soft; s_op(OP_OFF_SOFT) and power_run |-> ##2 power_run [*3]; endproperty
  a_soft: assert property (p_soft) else $error("abrupt off");
  property p_phase; phase_count inside {[5'd1:5'd16]}; endproperty
  a_phase: assert property (p_phase) else $error("bad count");
endmodule
bind pmc_output_control pmc_output_control_sva #(.STORE_CYCLES(STORE_CYCLES)) i_sva (
  .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .rsp_error(rsp_error), .cmd_busy(cmd_busy), .power_run(power_run),
  .vout_setpoint(vout_setpoint), .phase_count(phase_count), .clear_faults(clear_faults)
);

// >>> pmc_host_model.sv
// bus host model
module pmc_host_model
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic cmd_busy,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_error,
  input wire logic power_run,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic got;
  logic [15:0] rd;
  logic er;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one command; raw skips the wait for idle
  // a lone module is its own reference
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input bit raw);
    int n;
    n = 0;
    if (w && c == CMD_FREQ && power_run === 1'b1) return;
    while (!raw && cmd_busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c; // no stale value
    cmd_wdata <= ~d;
    #1;
    got = rsp_valid;
    rd = rsp_rdata;
    er = rsp_error;
  endtask
endmodule

// >>> tb_pmbus_output_control_commands.sv
// output control bench
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_pmbus_output_control_commands;
  import pmc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] CEIL_EXP = 16'(32'h2000 * CEIL_PCT / PCT_BASE);
  logic clk = 1'b0, reset_n = 1'b0, enable_pin = 1'b0;
  logic [7:0] load_amps = 8'h00;
  logic [15:0] strap_vout = 16'h2000;
  logic cmd_valid, cmd_write, rsp_valid, rsp_error, cmd_busy, power_run, clear_faults;
  logic [7:0] cmd_code, security_level;
  logic [15:0] cmd_wdata, rsp_rdata, vout_setpoint, duty_limit, switch_freq;
  logic [3:0] phase_group, phase_pos;
  logic [4:0] phase_count;
  int fail_count = 0;
  int checks = 0;
  always #5 clk = ~clk;
  pmc_output_control #(.STORE_CYCLES(20)) i_dut (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .load_amps(load_amps), .enable_pin(enable_pin), .strap_vout(strap_vout),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .cmd_busy(cmd_busy),
    .power_run(power_run), .vout_setpoint(vout_setpoint), .duty_limit(duty_limit),
    .switch_freq(switch_freq), .phase_group(phase_group), .phase_count(phase_count),
    .phase_pos(phase_pos), .security_level(security_level), .clear_faults(clear_faults));
  pmc_host_model i_host (.clk(clk), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .power_run(power_run),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  // bus helpers
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_host.xfer(1'b1, c, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] c);
    i_host.xfer(1'b0, c, 16'h0000, 1'b0);
  endtask
  task automatic wait_run(input logic r, input int n);
    for (int i = 0; i < n && power_run !== r; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("power_run", r, power_run)
  endtask
  task automatic wait_sp(input logic [15:0] v, input int n);
    for (int i = 0; i < n && vout_setpoint !== v; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("vout_setpoint", v, vout_setpoint)
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    enable_pin <= v;
  endtask
  // register reset values
  task automatic t_reset;
    logic [7:0] c[8] = '{CMD_OPERATION, CMD_START_CFG, CMD_VOUT_FORMAT, CMD_ADJUST, CMD_CAL,
      CMD_SLEW, CMD_SLOPE, CMD_DUTY};
    logic [15:0] e[8] = '{OP_RST, START_CFG_RST, VOUT_FORMAT_VAL, ADJUST_RST, CAL_RST,
      SLEW_RST, SLOPE_RST, DUTY_RST};
    for (int i = 0; i < 8; i++) begin
      rd(c[i]);
      `CHK("reset value", e[i], i_host.rd)
    end
    `CHK("duty_limit", DUTY_RST, duty_limit)
    `CHK("security_level", SEC_LEVEL_ONE, security_level)
  endtask
  // refusals and fields
  task automatic t_fields;
    wr(CMD_VOUT_FORMAT, 16'h0055);
    `CHK("format write", 1'b1, i_host.er)
    rd(CMD_VOUT_FORMAT);
    `CHK("format read", VOUT_FORMAT_VAL, i_host.rd)
    rd(CMD_CLEAR_FAULTS);
    `CHK("send byte read", 1'b1, i_host.er)
    wr(CMD_PHASE, 16'hF321);
    rd(CMD_PHASE);
    `CHK("phase word", 16'h0321, i_host.rd)
    `CHK("phase fields", 13'h0621, {phase_group, phase_count, phase_pos})
    wr(CMD_PHASE, 16'h0705);
    `CHK("phase fields", 13'h0F05, {phase_group, phase_count, phase_pos})
    wr(CMD_ADJUST, 16'h8000);
    rd(CMD_ADJUST);
    `CHK("adjust word", 16'h8000, i_host.rd)
    wr(CMD_ADJUST, 16'h0000);
  endtask
  // bus start, trim, offset, off
  task automatic t_bus;
    wr(CMD_START_CFG, {8'h00, CFG_BUS});
    wr(CMD_TARGET, 16'h2000);
    wr(CMD_OPERATION, {8'h00, OP_ON_NOM});
    wait_run(1'b1, 3);
    wait_sp(16'h2000, 3);
    wr(CMD_ADJUST, 16'h0010);
    wait_sp(16'h2010, 400);
    wr(CMD_CAL, 16'hFFF0);
    wait_sp(16'h2000, 400);
    wr(CMD_OPERATION, {8'h00, OP_OFF_NOW});
    wait_run(1'b0, 3);
    `CHK("setpoint off", 16'h0000, vout_setpoint)
  endtask
  // margins, clamps, droop, soft off
  task automatic t_margin;
    wr(CMD_SLEW, SLEW_FASTEST);
    wr(CMD_MARGIN_HI, 16'h2100);
    wr(CMD_MARGIN_LO, 16'h1F00);
    wr(CMD_OPERATION, {8'h00, OP_ON_HIGH});
    wait_sp(16'h2100, 3);
    wr(CMD_OPERATION, {8'h00, OP_ON_LOW});
    wait_sp(16'h1F00, 250);
    wr(CMD_MARGIN_HI, 16'h3000);
    wr(CMD_OPERATION, {8'h00, OP_ON_HIGH});
    wait_sp(CEIL_EXP, 250);
    wr(CMD_CEILING, 16'h2080);
    wait_sp(16'h2080, 250);
    wr(CMD_CEILING, CEIL_EXP);
    wr(CMD_MARGIN_HI, 16'h2100);
    @(posedge clk);
    load_amps <= 8'h04;
    wr(CMD_SLOPE, 16'h0001);
    wait_sp(16'h20E0, 250);
    wr(CMD_SLEW, SLEW_RST);
    wr(CMD_OPERATION, {8'h00, OP_OFF_SOFT});
    repeat (3) @(posedge clk);
    `CHK("soft off", 1'b1, power_run)
    wr(CMD_OPERATION, {8'h00, OP_OFF_NOW});
    wait_run(1'b0, 3);
    wr(CMD_SLOPE, 16'h0000);
  endtask
  // pin and always-on modes
  task automatic t_pin;
    wr(CMD_START_CFG, {8'h00, CFG_PIN_HARD});
    pin(1'b1);
    wait_run(1'b1, 8);
    pin(1'b0);
    wait_run(1'b0, 8);
    wr(CMD_START_CFG, {8'h00, CFG_PIN_SOFT});
    pin(1'b1);
    wait_run(1'b1, 8);
    pin(1'b0);
    repeat (4) @(posedge clk);
    `CHK("pin soft off", 1'b1, power_run)
    wr(CMD_START_CFG, {8'h00, CFG_PIN_HARD});
    wait_run(1'b0, 8);
    wr(CMD_START_CFG, {8'h00, CFG_ALWAYS});
    wait_run(1'b1, 8);
    wr(CMD_OPERATION, {8'h00, OP_OFF_NOW});
    repeat (3) @(posedge clk);
    `CHK("always on", 1'b1, power_run)
    wr(CMD_START_CFG, {8'h00, CFG_PIN_HARD});
    wait_run(1'b0, 8);
    wr(CMD_START_CFG, {8'h00, CFG_BUS});
  endtask
  // clear faults, stores and restores
  task automatic t_store;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    repeat (3) @(posedge clk);
    `CHK("no restart", 1'b0, power_run)
    wr(CMD_TARGET, 16'h1234);
    wr(CMD_STORE_USER, 16'h0000);
    `CHK("store busy", 1'b1, cmd_busy)
    i_host.xfer(1'b0, CMD_TARGET, 16'h0000, 1'b1);
    `CHK("busy drop", 1'b0, i_host.got)
    wr(CMD_TARGET, 16'h0800);
    wr(CMD_RESTORE_USER, 16'h0000);
    rd(CMD_TARGET);
    `CHK("user restore", 16'h1234, i_host.rd)
    `CHK("security_level", SEC_LEVEL_ONE, security_level)
    wr(CMD_TARGET, 16'h2000);
    wr(CMD_STORE_DEFAULT, 16'h0000);
    `CHK("store busy", 1'b1, cmd_busy)
    wr(CMD_TARGET, 16'h0400);
    wr(CMD_RESTORE_DEFAULT, 16'h0000);
    rd(CMD_TARGET);
    `CHK("default restore", 16'h2000, i_host.rd)
    `CHK("security_level", SEC_LEVEL_ONE, security_level)
  endtask
  task automatic summarize;
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_bus();
    t_margin();
    t_pin();
    t_store();
    summarize();
  end
  // watchdog
  initial begin
    #500000;
    fail_count++;
    summarize();
  end
endmodule
